/* File: rtl/ulp_lpm_flags.sv */
// LPM status flags, payload address and interrupt registers
//
// The Wishbone interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
module ulp_lpm_flags
   import ulp_pkg::*;
#(
   parameter logic [15:0] LINK_OK = ULP_LINK_OK_DEF
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // USB core role and events
   input wire logic host_mode_i,
   input wire logic usb_resume_i,
   input wire logic lpm_txn_i,
   input wire logic [5:0] flag_ack_i,
   // Device role: received LPM
   input wire logic lpm_rx_i,
   input wire logic [3:0] link_state_i,
   input wire logic rx_fifo_pending_i,
   // Host role: answer from attached device
   input wire logic host_hs_valid_i,
   input wire ulp_hs_t host_hs_i,
   // Answer to a received LPM
   output logic hs_valid_o,
   output ulp_hs_t hs_code_o,
   // Payload address and interrupt
   output logic [6:0] lpm_payload_function_address_o,
   output logic irq_o
);

   typedef struct packed {
      logic [6:0] faddr;
      logic [5:0] flags;
      logic [5:0] int_stat;
      logic [5:0] int_mask;
      ulp_hs_t last_hs;
      logic irq;
   } ulp_flags_t;

   ulp_flags_t s_reg, s_next;

   ulp_regbus_if rb ();

   logic dev_hs_valid;
   ulp_hs_t dev_hs;
   logic ev_err;
   logic ev_nc;
   logic ev_ack;
   logic ev_ny;
   logic [5:0] set_vec;
   logic host_ev;

   // Set wins over a clear arriving in the same cycle
   function automatic logic [5:0] set_clr(
      input logic [5:0] cur,
      input logic [5:0] set,
      input logic [5:0] clr
   );
      set_clr = (cur & ~clr) | set;
   endfunction

   // Writes reach only the byte lanes that sel enables
   function automatic logic [31:0] lane_mask(input logic [3:0] sel);
      lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
   endfunction

   function automatic logic [31:0] flag_word(input logic [5:0] v);
      flag_word = {26'h000_0000, v};
   endfunction

   ulp_wb_slave u_wbs (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o),
      .rb(rb.bus)
   );

   ulp_lpm_responder #(
      .LINK_OK(LINK_OK)
   ) u_rsp (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .lpm_rx_i(lpm_rx_i & ~host_mode_i),
      .link_state_i(link_state_i),
      .rx_fifo_pending_i(rx_fifo_pending_i),
      .hs_valid_o(dev_hs_valid),
      .hs_code_o(dev_hs),
      .ev_err_o(ev_err),
      .ev_nc_o(ev_nc),
      .ev_ack_o(ev_ack),
      .ev_ny_o(ev_ny)
   );

   assign hs_valid_o = dev_hs_valid;
   assign hs_code_o = dev_hs;
   assign lpm_payload_function_address_o = s_reg.faddr;
   assign irq_o = s_reg.irq;

   // Host answers only count while host role is selected
   assign host_ev = host_hs_valid_i & host_mode_i;

   always_comb begin
      set_vec = 6'h00;
      set_vec[ULP_FLAG_ERR] = ev_err;
      set_vec[ULP_FLAG_RES] = usb_resume_i;
      set_vec[ULP_FLAG_NC] = ev_nc | (host_ev & (host_hs_i == ULP_HS_ACK));
      set_vec[ULP_FLAG_ACK] = ev_ack | (host_ev & (host_hs_i == ULP_HS_ACK));
      set_vec[ULP_FLAG_NY] = ev_ny | (host_ev & (host_hs_i == ULP_HS_NYET));
      set_vec[ULP_FLAG_TXN] = lpm_txn_i;
   end

   // Read mux; unmapped offsets and unused bits read zero
   always_comb begin
      rb.rdata = 32'h0000_0000;
      case (rb.adr)
         ULP_OFS_CTRL2: begin
            rb.rdata[ULP_FADDR_LSB +: ULP_FADDR_W] = s_reg.faddr;
            rb.rdata[ULP_FLAG_W-1:0] = s_reg.flags;
         end
         ULP_OFS_INT_STAT: begin
            rb.rdata = flag_word(s_reg.int_stat);
         end
         ULP_OFS_INT_MASK: begin
            rb.rdata = flag_word(s_reg.int_mask);
         end
         ULP_OFS_STATE: begin
            rb.rdata[ULP_ST_ROLE] = host_mode_i;
            rb.rdata[ULP_ST_HS_LSB +: 2] = s_reg.last_hs;
            rb.rdata[ULP_ST_IRQ] = s_reg.irq;
         end
         default: begin
            rb.rdata = 32'h0000_0000;
         end
      endcase
   end

   always_comb begin
      logic [31:0] wm;
      logic [5:0] w1c;
      wm = lane_mask(rb.sel);
      w1c = 6'h00;
      s_next = s_reg;
      if (rb.acc && rb.we) begin
         case (rb.adr)
            ULP_OFS_CTRL2: begin
               // Only the address field is writable; flags ignore writes
               if (wm[ULP_FADDR_LSB]) begin
                  s_next.faddr = rb.wdata[ULP_FADDR_LSB +: ULP_FADDR_W];
               end
            end
            ULP_OFS_INT_STAT: begin
               w1c = rb.wdata[ULP_FLAG_W-1:0] & wm[ULP_FLAG_W-1:0];
            end
            ULP_OFS_INT_MASK: begin
               if (wm[0]) begin
                  s_next.int_mask = rb.wdata[ULP_FLAG_W-1:0];
               end
            end
            default: begin
               w1c = 6'h00;
            end
         endcase
      end
      // Flags cleared only by the core, never by software
      s_next.flags = set_clr(s_reg.flags, set_vec, flag_ack_i);
      s_next.int_stat = set_clr(s_reg.int_stat, set_vec, w1c);
      if (dev_hs_valid) begin
         s_next.last_hs = dev_hs;
      end
      s_next.irq = |(s_next.int_stat & s_next.int_mask);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_reg <= '{
            faddr: ULP_FADDR_RST,
            flags: ULP_FLAGS_RST,
            int_stat: ULP_FLAGS_RST,
            int_mask: ULP_MASK_RST,
            last_hs: ULP_HS_NONE,
            irq: 1'b0
         };
      end else begin
         s_reg <= s_next;
      end
   end
endmodule

/* File: rtl/ulp_pkg.sv */
// Shared constants and types for the LPM status and flag block
// How it works
// - Seven-bit read/write function address for the LPM payload sits in bits 14 to 8.
// - Device role: unsupported link state in a received LPM sets bit 5.
// - Device role: an LPM naming an unsupported link state is answered with STALL.
// - Any resume of the USB controller sets bit 4.
// - Device role: pending receive FIFO data with a supported link state makes the answer NYET and sets bit 3.
// - Host role: LPM sent and answered with ACK sets bit 3.
// - Device role: received LPM answered with ACK sets bit 2.
// - Host role: LPM sent and answered with ACK sets bit 2.
// - Device role: received LPM answered with NYET sets bit 1.
// - Host role: LPM sent and answered with NYET sets bit 1.
// - Bits 31 to 15 and 7 to 6 read zero, writes ignored.
package ulp_pkg;

   // Register byte offsets
   localparam logic [7:0] ULP_OFS_CTRL2 = 8'h00;
   localparam logic [7:0] ULP_OFS_INT_STAT = 8'h04;
   localparam logic [7:0] ULP_OFS_INT_MASK = 8'h08;
   localparam logic [7:0] ULP_OFS_STATE = 8'h0c;

   // Field layout
   localparam int ULP_FADDR_LSB = 8;
   localparam int ULP_FADDR_W = 7;
   localparam int ULP_FLAG_W = 6;
   localparam int ULP_FLAG_ERR = 5;
   localparam int ULP_FLAG_RES = 4;
   localparam int ULP_FLAG_NC = 3;
   localparam int ULP_FLAG_ACK = 2;
   localparam int ULP_FLAG_NY = 1;
   localparam int ULP_FLAG_TXN = 0;
   localparam int ULP_ST_ROLE = 0;
   localparam int ULP_ST_HS_LSB = 1;
   localparam int ULP_ST_IRQ = 3;

   // Reset values
   localparam logic [6:0] ULP_FADDR_RST = 7'h00;
   localparam logic [5:0] ULP_FLAGS_RST = 6'h00;
   localparam logic [5:0] ULP_MASK_RST = 6'h00;

   // Link states accepted by default, one bit per state value
   localparam logic [15:0] ULP_LINK_OK_DEF = 16'h0002;

   typedef enum logic [1:0] {
      ULP_HS_ACK,
      ULP_HS_NYET,
      ULP_HS_STALL,
      ULP_HS_NONE
   } ulp_hs_t;

endpackage

/* File: rtl/ulp_regbus_if.sv */
// Internal register access channel between bus slave and register file
`timescale 1ns/100ps
interface ulp_regbus_if;
   logic acc;
   logic we;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] wdata;
   logic [31:0] rdata;

   modport bus (output acc, output we, output adr, output sel, output wdata, input rdata);
   modport regs (input acc, input we, input adr, input sel, input wdata, output rdata);
endinterface

/* File: rtl/ulp_wb_slave.sv */
// Classic Wishbone slave front end with one-cycle answer
`timescale 1ns/100ps
module ulp_wb_slave (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Register side
   ulp_regbus_if.bus rb
);
   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } ulp_wbs_t;

   ulp_wbs_t s_reg, s_next;

   // Commit at the edge where the master sees ack, never earlier
   assign rb.acc = wb_cyc_i & wb_stb_i & s_reg.ack;
   assign rb.we = wb_we_i;
   assign rb.adr = wb_adr_i;
   assign rb.sel = wb_sel_i;
   assign rb.wdata = wb_dat_i;
   assign wb_ack_o = s_reg.ack;
   assign wb_dat_o = s_reg.dat;

   always_comb begin
      s_next = s_reg;
      s_next.ack = wb_cyc_i & wb_stb_i & ~s_reg.ack;
      // Read data sampled as ack rises, stable while ack is high
      if (wb_cyc_i & wb_stb_i & ~s_reg.ack) begin
         s_next.dat = wb_we_i ? 32'h0000_0000 : rb.rdata;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end
endmodule

/* File: rtl/ulp_lpm_responder.sv */
// Device-role handshake choice for received LPM transactions
`timescale 1ns/100ps
module ulp_lpm_responder
   import ulp_pkg::*;
#(
   parameter logic [15:0] LINK_OK = ULP_LINK_OK_DEF
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Received LPM
   input wire logic lpm_rx_i,
   input wire logic [3:0] link_state_i,
   input wire logic rx_fifo_pending_i,
   // Answer valid and events are one-cycle pulses; answer code holds until the next LPM
   output logic hs_valid_o,
   output ulp_hs_t hs_code_o,
   output logic ev_err_o,
   output logic ev_nc_o,
   output logic ev_ack_o,
   output logic ev_ny_o
);
   typedef struct packed {
      logic vld;
      ulp_hs_t hs;
      logic err;
      logic nc;
      logic ack;
      logic ny;
   } ulp_rsp_t;

   ulp_rsp_t s_reg, s_next;

   assign hs_valid_o = s_reg.vld;
   assign hs_code_o = s_reg.hs;
   assign ev_err_o = s_reg.err;
   assign ev_nc_o = s_reg.nc;
   assign ev_ack_o = s_reg.ack;
   assign ev_ny_o = s_reg.ny;

   always_comb begin
      s_next = '0;
      s_next.hs = s_reg.hs;
      if (lpm_rx_i) begin
         s_next.vld = 1'b1;
         // Unsupported state outranks pending data: STALL, not NYET
         if (!LINK_OK[link_state_i]) begin
            s_next.hs = ULP_HS_STALL;
            s_next.err = 1'b1;
         end else if (rx_fifo_pending_i) begin
            s_next.hs = ULP_HS_NYET;
            s_next.nc = 1'b1;
            s_next.ny = 1'b1;
         end else begin
            s_next.hs = ULP_HS_ACK;
            s_next.ack = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_reg <= '{vld: 1'b0, hs: ULP_HS_NONE, default: 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end
endmodule

/* File: testbench/ulp_lpm_flags_properties.sv */
// Port-level assertions for the LPM flag block
`timescale 1ns/100ps
module ulp_lpm_flags_properties
   import ulp_pkg::*;
#(
   parameter logic [15:0] LINK_OK = ULP_LINK_OK_DEF
) (
   // Clock, reset and bus
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // LPM traffic
   input wire logic host_mode_i,
   input wire logic lpm_rx_i,
   input wire logic [3:0] link_state_i,
   input wire logic rx_fifo_pending_i,
   input wire logic hs_valid_o,
   input wire ulp_hs_t hs_code_o,
   input wire logic [6:0] lpm_payload_function_address_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [6:0] wdat_reg;
   always_ff @(posedge clk_i) begin
      wdat_reg <= wb_dat_i[14:8];
   end
   sequence s_dev_rx;
      lpm_rx_i && !host_mode_i;
   endsequence
   sequence s_addr_wr;
      wb_ack_o && wb_we_i && wb_sel_i[1] && wb_adr_i == ULP_OFS_CTRL2;
   endsequence
   property p_stall;
      s_dev_rx ##0 !LINK_OK[link_state_i] |=> hs_valid_o && hs_code_o == ULP_HS_STALL;
   endproperty
   a_stall: assert property (p_stall) else $error("stall answer missing");
   property p_nyet;
      s_dev_rx ##0 (LINK_OK[link_state_i] && rx_fifo_pending_i) |=> hs_code_o == ULP_HS_NYET;
   endproperty
   a_nyet: assert property (p_nyet) else $error("nyet answer missing");
   property p_ack;
      s_dev_rx ##0 (LINK_OK[link_state_i] && !rx_fifo_pending_i) |=> hs_code_o == ULP_HS_ACK;
   endproperty
   a_ack: assert property (p_ack) else $error("ack answer missing");
   property p_host_quiet;
      lpm_rx_i && host_mode_i |=> !hs_valid_o;
   endproperty
   a_host_quiet: assert property (p_host_quiet) else $error("answer in host role");
   property p_wb_ack;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_wb_ack: assert property (p_wb_ack) else $error("bus ack late");
   property p_ack_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("bus ack too long");
   property p_reserved;
      wb_ack_o && !wb_we_i && wb_adr_i == ULP_OFS_CTRL2 |-> wb_dat_o[31:15] == 17'h0
         && wb_dat_o[7:6] == 2'h0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("unused bits not zero");
   property p_addr;
      s_addr_wr |=> lpm_payload_function_address_o == wdat_reg;
   endproperty
   a_addr: assert property (p_addr) else $error("address not stored");
endmodule

bind ulp_lpm_flags ulp_lpm_flags_properties #(.LINK_OK(LINK_OK)) chk_u (.clk_i, .rst_i,
   .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
   .host_mode_i, .lpm_rx_i, .link_state_i, .rx_fifo_pending_i, .hs_valid_o, .hs_code_o,
   .lpm_payload_function_address_o);

/* File: testbench/ulp_usb_far_model.sv */
// Far USB party: sends LPM tokens and host-role answers
`timescale 1ns/100ps
module ulp_usb_far_model
   import ulp_pkg::*;
(
   // Clock
   input wire logic clk_i,
   // Toward the block
   output logic lpm_rx_o = 1'b0,
   output logic [3:0] link_state_o = 4'h0,
   output logic pend_o = 1'b0,
   output logic hs_valid_o = 1'b0,
   output ulp_hs_t hs_o = ULP_HS_NONE
);
   // Gap gives prompt or slow traffic
   task automatic send_lpm(input logic [3:0] st, input logic pd, input int gap);
      repeat (gap + 1) @(posedge clk_i);
      lpm_rx_o <= 1'b1;
      link_state_o <= st;
      pend_o <= pd;
      @(posedge clk_i);
      lpm_rx_o <= 1'b0;
      // Stale fields shown inverted so no old value passes
      link_state_o <= ~st;
      pend_o <= ~pd;
   endtask
   task automatic answer(input ulp_hs_t hs, input int gap);
      repeat (gap + 1) @(posedge clk_i);
      hs_valid_o <= 1'b1;
      hs_o <= hs;
      @(posedge clk_i);
      hs_valid_o <= 1'b0;
      hs_o <= ulp_hs_t'(~hs);
   endtask
endmodule

/* File: testbench/testbench.sv */
// Self-checking bench for the LPM flag block
`timescale 1ns/100ps
module testbench;
   import ulp_pkg::*;
   typedef struct {logic [3:0] st; logic pd; ulp_hs_t hs; logic [5:0] fl;} ulp_row_t;
   logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic host_mode_i = 1'b0, usb_resume_i = 1'b0, lpm_txn_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hf;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
   logic [5:0] flag_ack_i = 6'h00;
   logic wb_ack_o, lpm_rx_i, rx_fifo_pending_i, host_hs_valid_i, hs_valid_o, irq_o;
   logic [3:0] link_state_i;
   logic [6:0] lpm_payload_function_address_o;
   ulp_hs_t host_hs_i, hs_code_o;
   int n_mismatch = 0, n_compared = 0;
   ulp_row_t rows [4] = '{'{4'h1, 1'b0, ULP_HS_ACK, 6'h04}, '{4'h1, 1'b1, ULP_HS_NYET, 6'h0a},
      '{4'h0, 1'b0, ULP_HS_STALL, 6'h20}, '{4'hf, 1'b1, ULP_HS_STALL, 6'h20}};
   ulp_lpm_flags dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .host_mode_i(host_mode_i),
      .usb_resume_i(usb_resume_i), .lpm_txn_i(lpm_txn_i), .flag_ack_i(flag_ack_i),
      .lpm_rx_i(lpm_rx_i), .link_state_i(link_state_i), .rx_fifo_pending_i(rx_fifo_pending_i),
      .host_hs_valid_i(host_hs_valid_i), .host_hs_i(host_hs_i), .hs_valid_o(hs_valid_o),
      .hs_code_o(hs_code_o), .lpm_payload_function_address_o(lpm_payload_function_address_o),
      .irq_o(irq_o));
   ulp_usb_far_model far_u (.clk_i(clk_i), .lpm_rx_o(lpm_rx_i), .link_state_o(link_state_i),
      .pend_o(rx_fifo_pending_i), .hs_valid_o(host_hs_valid_i), .hs_o(host_hs_i));
   always #20 clk_i = ~clk_i;
   task automatic close_out;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         $display("BAD %s expected %h seen %h", nm, e, g);
         n_mismatch++;
      end
   endtask
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      i = 0;
      do begin
         @(posedge clk_i);
         i++;
      end while (wb_ack_o !== 1'b1 && i < 16);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (i >= 16) begin
         n_mismatch++;
         close_out();
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      wb(1'b0, a, 32'h0);
      chk(nm, e, q);
   endtask
   // Pulses {resume, txn, flag clear}
   task automatic ev(input logic [7:0] v);
      @(posedge clk_i);
      {usb_resume_i, lpm_txn_i, flag_ack_i} <= v;
      @(posedge clk_i);
      {usb_resume_i, lpm_txn_i, flag_ack_i} <= 8'h00;
   endtask
   task automatic clr;
      ev(8'h3f);
      wb(1'b1, ULP_OFS_INT_STAT, 32'h3f);
   endtask
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(ULP_OFS_CTRL2, 32'h0, "ctrl2 reset");
      rd(ULP_OFS_INT_MASK, 32'h0, "mask reset");
      chk("hs reset", ULP_HS_NONE, hs_code_o);
      $display("test reset done");
      foreach (rows[k]) begin
         far_u.send_lpm(rows[k].st, rows[k].pd, k);
         rd(ULP_OFS_CTRL2, {26'h0, rows[k].fl}, "device flags");
         chk("hs code", rows[k].hs, hs_code_o);
         clr();
      end
      $display("test device rows done");
      host_mode_i <= 1'b1;
      far_u.answer(ULP_HS_ACK, 0);
      rd(ULP_OFS_CTRL2, 32'h0c, "host ack");
      clr();
      far_u.answer(ULP_HS_NYET, 2);
      rd(ULP_OFS_CTRL2, 32'h02, "host nyet");
      far_u.answer(ULP_HS_STALL, 0);
      far_u.send_lpm(4'h1, 1'b0, 0);
      rd(ULP_OFS_CTRL2, 32'h02, "host quiet");
      clr();
      host_mode_i <= 1'b0;
      $display("test host done");
      wb(1'b1, ULP_OFS_CTRL2, 32'hffffffff);
      ev(8'hc0);
      rd(ULP_OFS_CTRL2, 32'h7f11, "addr and flags");
      chk("addr out", 32'h7f, lpm_payload_function_address_o);
      clr();
      rd(ULP_OFS_CTRL2, 32'h7f00, "flags cleared");
      $display("test register done");
      wb(1'b1, ULP_OFS_INT_MASK, 32'h20);
      ev(8'h80);
      rd(ULP_OFS_INT_STAT, 32'h10, "status");
      chk("irq masked", 32'h0, irq_o);
      far_u.send_lpm(4'h0, 1'b0, 0);
      rd(ULP_OFS_INT_STAT, 32'h30, "status err");
      chk("irq on", 32'h1, irq_o);
      rd(ULP_OFS_STATE, 32'h0c, "state after stall");
      wb(1'b1, ULP_OFS_INT_STAT, 32'h30);
      rd(ULP_OFS_INT_STAT, 32'h0, "status clear");
      chk("irq off", 32'h0, irq_o);
      wb(1'b1, 8'h10, 32'hffffffff);
      rd(8'h10, 32'h0, "unmapped");
      $display("test interrupt done");
      // Core clear and resume in one cycle: the new event must survive
      wb(1'b1, ULP_OFS_INT_MASK, 32'h10);
      ev(8'hbf);
      rd(ULP_OFS_CTRL2, 32'h7f10, "set beats clear");
      chk("irq pre reset", 32'h1, irq_o);
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(ULP_OFS_CTRL2, 32'h0, "ctrl2 mid reset");
      rd(ULP_OFS_INT_MASK, 32'h0, "mask mid reset");
      chk("hs mid reset", ULP_HS_NONE, hs_code_o);
      chk("irq mid reset", 32'h0, irq_o);
      $display("test awkward done");
      close_out();
   end
endmodule
